// ---- src/mdic_defs.svh ----
/*
 * Constants of the motor driver input command logic: setting codes, defaults,
 * limits and timing counts. Assumes a 25 MHz core clock.
 */
`ifndef MDIC_DEFS_SVH
`define MDIC_DEFS_SVH

`define MDIC_MON0_DEF      4'h1
`define MDIC_MON1_DEF      4'h8
`define MDIC_MON_ALARM     4'h8
`define MDIC_MON_LAST      4'hc
`define MDIC_LEN_POS       6'h20
`define MDIC_LEN_ALM       6'h08
`define MDIC_LEN_BOTH      6'h28
`define MDIC_PLS_FREQ_DEF  14'h0064
`define MDIC_PLS_FREQ_MAX  14'h2710
`define MDIC_ETO_LEVEL     2'h2
`define MDIC_POSITION_INPUT_A_KEEP    8'hff
`define MDIC_POSITION_INPUT_A_ABS     8'h01
`define MDIC_POSITION_INPUT_A_WRAP    8'h08
`define MDIC_MULT_DEF      5'h0a
`define MDIC_MULT_MIN      5'h02
`define MDIC_MULT_MAX      5'h1e
`define MDIC_CLK_HZ        25000000
`define MDIC_FREQ_UNIT_HZ  100
`define MDIC_NCO_HALF      18'(`MDIC_CLK_HZ / (2 * `MDIC_FREQ_UNIT_HZ))

`endif

// ---- src/mdic_pkg.sv ----
/*
 * Types of the motor driver input command logic.
 * Assumes mdic_defs.svh for all numeric constants.
 */
package mdic_pkg;

    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] fb;
        logic [31:0] cmd_cnt;
        logic [31:0] fb_cnt;
    } mdic_pos_t;

    typedef struct packed {
        logic       monitor_request_0;
        logic       monitor_request_1;
        logic       pulse_report_request;
        logic       alarm_reset_input;
        logic       estop_clear_input;
        logic       latch_clear_input;
        logic       info_clear_input;
        logic       tool_permission_direct;
        logic       tool_permission_remote;
        logic       position_input_a;
        logic       pulse_multiply_input;
        logic       pulse_disable_input;
        logic       command_pulse;
        logic [7:0] data_select;
    } mdic_pins_t;

    typedef struct packed {
        logic [31:0] cmd;
        logic [31:0] fb;
        logic [31:0] target;
        logic [7:0]  op_num;
        logic [7:0]  loops;
    } mdic_latch_t;

    typedef struct packed {
        logic        valid;
        logic [7:0]  index;
        logic [31:0] position;
        logic        type_valid;
        logic [7:0]  op_type;
    } mdic_position_input_a_t;

    typedef struct packed {
        logic [39:0] word;
        logic [5:0]  len;
    } mdic_frame_t;

    typedef enum logic [1:0] {
        PLS_IDLE = 2'b00,
        PLS_HIGH = 2'b01,
        PLS_LOW  = 2'b10
    } mdic_pls_state_t;

endpackage : mdic_pkg

// ---- src/mdic_sync.sv ----
/*
 * Three-stage input synchroniser with level and rising-edge outputs.
 * Assumes asynchronous pin inputs; level changes once stages two and three agree.
 */
`timescale 1ns/100ps
module mdic_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] level,
    output logic      [W-1:0] rise
);
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;

    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk) begin
            if (rst) begin
                s1[i]    <= 1'b0;
                s2[i]    <= 1'b0;
                s3[i]    <= 1'b0;
                level[i] <= 1'b0;
                rise[i]  <= 1'b0;
            end else begin
                s1[i]   <= din[i];
                s2[i]   <= s1[i];
                s3[i]   <= s2[i];
                rise[i] <= (s2[i] == s3[i]) && s3[i] && !level[i];
                if (s2[i] == s3[i]) begin
                    level[i] <= s3[i];
                end
            end
        end
    end

endmodule : mdic_sync

// ---- src/mdic_top.sv ----
/*
 * Motor driver input command logic: position monitor output (serial and
 * pulse train), status clearing, tool permission, teaching, pulse input gating.
 * Assumes settings and state inputs are steady on clk; pins are asynchronous;
 * the monitor shift clock is supplied by the host controller.
 */
// Summary of operation
// [RQ1] while a monitor request is on, output the data its selection chooses
// [RQ2] selection codes 1-4, 8, 9-12; defaults 1 and 8
// [RQ3] host clocks monitor data; each rising shift clock drives the next bit; here the first two edges of each frame carry no data
// [RQ4] in pulse mode a rising shift clock starts the pulse train
// [RQ5] rising pulse report request captures the coordinate to report
// [RQ6] pulse data codes 0-3 pick command/feedback, plain or counter; default 0
// [RQ7] pulse frequency 1 to 10000 in 0.1 kHz steps, default 100
// [RQ8] rising alarm reset clears a clearable alarm; locked alarms stay
// [RQ9] estop clear releases only the estop mode, and only once its cause is gone
// [RQ10] estop clear trigger: 1 rising edge, 2 high level; default 1
// [RQ11] latch clear wipes latch outputs, records, pulse-lost and cumulative load
// [RQ12] with auto clear off, info status releases while info clear is on
// [RQ13] tool permission off blocks tool test, position_input_a, remote, write, download, init; position_input_a writes are not gated here
// [RQ14] unassigned permission reads on; assigned to both needs both on
// [RQ15] the configuring party must not set one-shot on the permission mapping
// [RQ16] rising position_input_a input writes current position to the selected data entry
// [RQ17] position_input_a type setting: -1 keep type, 1 absolute, 8 wrap absolute; default 1
// [RQ18] multiply input on scales pulse count and frequency by 2 to 30, default 10
// [RQ19] the pulse source keeps input pulses below 1 MHz when multiplying
// [RQ20] pulse disable input on ignores every command pulse
// [RQ21] auto info clear, default on, drops info status once its cause is gone
// [RQ22] all pins are synchronised and edges detected once from the samples
`timescale 1ns/100ps
`include "mdic_defs.svh"
module mdic_top
    import mdic_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             monitor_shift_clock,
    input  wire mdic_pins_t       pins,
    input  wire logic             pulse_mode,
    input  wire logic [3:0]       mon_sel0,
    input  wire logic [3:0]       mon_sel1,
    input  wire logic [1:0]       pls_sel,
    input  wire logic [13:0]      pls_freq,
    input  wire mdic_pos_t        positions,
    input  wire logic             alarm_event,
    input  wire logic [7:0]       alarm_event_code,
    input  wire logic             alarm_event_locked,
    input  wire logic             eto_event,
    input  wire logic             eto_cause,
    input  wire logic [1:0]       eto_clear_mode,
    input  wire logic             info_cause,
    input  wire logic             info_auto_clear,
    input  wire logic [1:0]       tool_perm_assign,
    input  wire logic [3:0]       latch_event,
    input  wire mdic_latch_t      latch_now,
    input  wire logic             pulse_lost_event,
    input  wire logic             load_strobe,
    input  wire logic [15:0]      load_sample,
    input  wire logic [7:0]       position_input_a_type_setting,
    input  wire logic [4:0]       pulse_multiply_factor,
    output logic                  monitor_serial_output,
    output logic                  pulse_report_output,
    output logic                  pulse_report_dir,
    output logic                  alarm_present,
    output logic [7:0]            alarm_code,
    output logic                  external_torque_off_mode,
    output logic                  info_status,
    output logic                  tool_access_allowed,
    output logic                  next_latch_output,
    output logic                  jump_zero_latch_output,
    output logic                  jump_one_latch_output,
    output mdic_latch_t [3:0]     latch_records,
    output logic                  pulse_lost_output,
    output logic [31:0]           cumulative_load,
    output mdic_position_input_a_t           position_input_a_write,
    output logic [31:0]           command_pulse_count
);
    logic [21:0]     sy_lvl;
    logic [21:0]     sy_rise;
    mdic_pins_t      lvl;
    mdic_pins_t      rise;
    logic            mclk_lvl;
    logic            mclk_rise;
    logic [3:0]      sel_eff;
    logic [31:0]     sel_pos;
    mdic_frame_t     next_frame;
    mdic_frame_t     frame;
    logic            mon_active;
    logic            frame_tog;
    logic            alarm_locked;
    logic [3:0]      latch_hold;
    logic            eto_clear_trig;
    logic            next_allowed;
    logic [13:0]     freq_eff;
    logic [17:0]     nco_acc;
    logic [17:0]     nco_sum;
    logic            nco_tick;
    logic [31:0]     pls_count;
    logic [31:0]     pls_remaining;
    mdic_pls_state_t pls_state;
    logic [4:0]      mult_eff;
    logic            lk_rst_meta;
    logic            lk_rst;
    logic            lk_req_meta;
    logic            lk_req;
    logic            lk_tog_meta;
    logic            lk_tog;
    logic            lk_tog_seen;
    logic [5:0]      bit_cnt;

    mdic_sync #(.W(22)) u_sync (
        .clk   (clk),
        .rst   (rst),
        .din   ({pins, monitor_shift_clock}),
        .level (sy_lvl),
        .rise  (sy_rise)
    ); // [RQ22]

    assign lvl       = mdic_pins_t'(sy_lvl[21:1]);
    assign rise      = mdic_pins_t'(sy_rise[21:1]);
    assign mclk_lvl  = sy_lvl[0];
    assign mclk_rise = sy_rise[0];

    // monitor word selection; request 0 wins when both are on
    always_comb begin
        sel_eff = lvl.monitor_request_0 ? mon_sel0 : mon_sel1;
        if (!((sel_eff >= 4'h1 && sel_eff <= 4'h4)
              || (sel_eff >= `MDIC_MON_ALARM && sel_eff <= `MDIC_MON_LAST))) begin
            sel_eff = lvl.monitor_request_0 ? `MDIC_MON0_DEF : `MDIC_MON1_DEF; // [RQ2]
        end
        unique case (sel_eff[2:0])
            3'h1:    sel_pos = positions.fb;
            3'h2:    sel_pos = positions.fb_cnt;
            3'h3:    sel_pos = positions.cmd;
            3'h4:    sel_pos = positions.cmd_cnt;
            default: sel_pos = 32'h0000_0000;
        endcase
        if (sel_eff == `MDIC_MON_ALARM) begin
            next_frame.word = {32'h0000_0000, alarm_code};
            next_frame.len  = `MDIC_LEN_ALM;
        end else if (sel_eff > `MDIC_MON_ALARM) begin
            next_frame.word = {sel_pos, alarm_code};
            next_frame.len  = `MDIC_LEN_BOTH;
        end else begin
            next_frame.word = {8'h00, sel_pos};
            next_frame.len  = `MDIC_LEN_POS;
        end
    end

    // frame loads once per request and then stays frozen; the toggle tells the link side
    always_ff @(posedge clk) begin
        if (rst) begin
            mon_active <= 1'b0;
            frame_tog  <= 1'b0;
            frame      <= '0;
        end else begin
            mon_active <= (lvl.monitor_request_0 || lvl.monitor_request_1) && !pulse_mode;
            if (!mon_active && (lvl.monitor_request_0 || lvl.monitor_request_1)
                && !pulse_mode) begin
                frame     <= next_frame; // [RQ1]
                frame_tog <= !frame_tog;
            end
        end
    end

    // link side: one bit per rising shift clock, msb first
    always_ff @(posedge monitor_shift_clock) begin
        lk_rst_meta <= rst;
        lk_rst      <= lk_rst_meta;
        lk_req_meta <= mon_active;
        lk_req      <= lk_req_meta;
        lk_tog_meta <= frame_tog;
        lk_tog      <= lk_tog_meta;
    end

    // the shift clock stands still between frames, so a new frame is known by its
    // toggle; the two edges spent on the crossing carry no data
    always_ff @(posedge monitor_shift_clock) begin
        if (lk_rst) begin
            bit_cnt               <= 6'h00;
            lk_tog_seen           <= lk_tog;
            monitor_serial_output <= 1'b0;
        end else if (!lk_req) begin
            bit_cnt               <= 6'h00;
            monitor_serial_output <= 1'b0;
        end else if (lk_tog != lk_tog_seen) begin
            lk_tog_seen           <= lk_tog;
            monitor_serial_output <= frame.word[6'(frame.len - 6'h01)]; // [RQ3]
            bit_cnt               <= 6'h01;
        end else if (bit_cnt < frame.len) begin
            monitor_serial_output <= frame.word[6'(frame.len - 6'h01 - bit_cnt)]; // [RQ3]
            bit_cnt               <= bit_cnt + 6'h01;
        end else begin
            monitor_serial_output <= 1'b0;
        end
    end

    // pulse report: capture on request edge, emit count at programmed rate
    assign freq_eff = (pls_freq == 14'h0000 || pls_freq > `MDIC_PLS_FREQ_MAX)
                      ? `MDIC_PLS_FREQ_DEF : pls_freq; // [RQ7]
    assign nco_sum  = nco_acc + 18'(freq_eff);
    assign nco_tick = nco_sum >= `MDIC_NCO_HALF;

    always_ff @(posedge clk) begin
        if (rst) begin
            pls_count        <= 32'h0000_0000;
            pulse_report_dir <= 1'b0;
        end else if (rise.pulse_report_request) begin // [RQ5]
            unique case (pls_sel) // [RQ6]
                2'h0: begin
                    pls_count        <= positions.cmd[31] ? -positions.cmd : positions.cmd;
                    pulse_report_dir <= positions.cmd[31];
                end
                2'h1: begin
                    pls_count        <= positions.cmd_cnt;
                    pulse_report_dir <= 1'b0;
                end
                2'h2: begin
                    pls_count        <= positions.fb[31] ? -positions.fb : positions.fb;
                    pulse_report_dir <= positions.fb[31];
                end
                2'h3: begin
                    pls_count        <= positions.fb_cnt;
                    pulse_report_dir <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            pls_state           <= PLS_IDLE;
            pls_remaining       <= 32'h0000_0000;
            nco_acc             <= 18'h00000;
            pulse_report_output <= 1'b0;
        end else begin
            if (pls_state != PLS_IDLE) begin
                nco_acc <= nco_tick ? nco_sum - `MDIC_NCO_HALF : nco_sum;
            end
            unique case (pls_state)
                PLS_IDLE: begin
                    if (mclk_rise && pulse_mode && pls_count != 32'h0000_0000) begin
                        pls_state           <= PLS_HIGH; // [RQ4]
                        pls_remaining       <= pls_count;
                        nco_acc             <= 18'h00000;
                        pulse_report_output <= 1'b1;
                    end
                end
                PLS_HIGH: begin
                    if (nco_tick) begin
                        pls_state           <= PLS_LOW;
                        pulse_report_output <= 1'b0;
                    end
                end
                PLS_LOW: begin
                    if (nco_tick) begin
                        pls_remaining <= pls_remaining - 32'h0000_0001;
                        if (pls_remaining == 32'h0000_0001) begin
                            pls_state <= PLS_IDLE;
                        end else begin
                            pls_state           <= PLS_HIGH;
                            pulse_report_output <= 1'b1;
                        end
                    end
                end
                default: begin
                    pls_state           <= PLS_IDLE;
                    pulse_report_output <= 1'b0;
                end
            endcase
        end
    end

    // alarm: a new alarm in the reset cycle survives
    always_ff @(posedge clk) begin
        if (rst) begin
            alarm_present <= 1'b0;
            alarm_code    <= 8'h00;
            alarm_locked  <= 1'b0;
        end else if (alarm_event) begin
            alarm_present <= 1'b1;
            alarm_code    <= alarm_event_code;
            alarm_locked  <= alarm_event_locked;
        end else if (rise.alarm_reset_input && !alarm_locked) begin
            alarm_present <= 1'b0; // [RQ8]
            alarm_code    <= 8'h00;
        end
    end

    assign eto_clear_trig = (eto_clear_mode == `MDIC_ETO_LEVEL)
                            ? lvl.estop_clear_input : rise.estop_clear_input; // [RQ10]

    always_ff @(posedge clk) begin
        if (rst) begin
            external_torque_off_mode <= 1'b0;
        end else if (eto_event) begin
            external_torque_off_mode <= 1'b1;
        end else if (eto_clear_trig && !eto_cause) begin
            external_torque_off_mode <= 1'b0; // [RQ9]
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            info_status <= 1'b0;
        end else if (info_auto_clear) begin
            info_status <= info_cause; // [RQ21]
        end else if (info_cause) begin
            info_status <= 1'b1;
        end else if (lvl.info_clear_input) begin
            info_status <= 1'b0; // [RQ12]
        end
    end

    // an unassigned source counts as on
    assign next_allowed = (!tool_perm_assign[0] || lvl.tool_permission_direct)
                          && (!tool_perm_assign[1] || lvl.tool_permission_remote); // [RQ14]

    always_ff @(posedge clk) begin
        if (rst) begin
            tool_access_allowed <= 1'b0;
        end else begin
            tool_access_allowed <= next_allowed; // [RQ13]
        end
    end

    // latch records: 0 next, 1 jump zero, 2 jump one, 3 stop interruption
    for (genvar i = 0; i < 4; i++) begin : g_latch
        always_ff @(posedge clk) begin
            if (rst) begin
                latch_hold[i]    <= 1'b0;
                latch_records[i] <= '0;
            end else if (latch_event[i]) begin
                latch_hold[i]    <= 1'b1;
                latch_records[i] <= latch_now;
            end else if (rise.latch_clear_input) begin
                latch_hold[i]    <= 1'b0; // [RQ11]
                latch_records[i] <= '0;
            end
        end
    end

    assign next_latch_output      = latch_hold[0];
    assign jump_zero_latch_output = latch_hold[1];
    assign jump_one_latch_output  = latch_hold[2];

    always_ff @(posedge clk) begin
        if (rst) begin
            pulse_lost_output <= 1'b0;
            cumulative_load   <= 32'h0000_0000;
        end else begin
            if (pulse_lost_event) begin
                pulse_lost_output <= 1'b1;
            end else if (rise.latch_clear_input) begin
                pulse_lost_output <= 1'b0; // [RQ11]
            end
            if (rise.latch_clear_input) begin
                cumulative_load <= load_strobe ? 32'(load_sample) : 32'h0000_0000;
            end else if (load_strobe) begin
                cumulative_load <= cumulative_load + 32'(load_sample);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            position_input_a_write <= '0;
        end else begin
            position_input_a_write.valid <= rise.position_input_a; // [RQ16]
            if (rise.position_input_a) begin
                position_input_a_write.index      <= lvl.data_select;
                position_input_a_write.position   <= positions.fb;
                position_input_a_write.type_valid <= position_input_a_type_setting != `MDIC_POSITION_INPUT_A_KEEP; // [RQ17]
                position_input_a_write.op_type    <= (position_input_a_type_setting == `MDIC_POSITION_INPUT_A_WRAP)
                                          ? `MDIC_POSITION_INPUT_A_WRAP : `MDIC_POSITION_INPUT_A_ABS;
            end
        end
    end

    assign mult_eff = (pulse_multiply_factor < `MDIC_MULT_MIN
                       || pulse_multiply_factor > `MDIC_MULT_MAX)
                      ? `MDIC_MULT_DEF : pulse_multiply_factor;

    always_ff @(posedge clk) begin
        if (rst) begin
            command_pulse_count <= 32'h0000_0000;
        end else if (rise.command_pulse && !lvl.pulse_disable_input) begin // [RQ20]
            command_pulse_count <= command_pulse_count
                + (lvl.pulse_multiply_input ? 32'(mult_eff) : 32'h0000_0001); // [RQ18]
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_ALM_CLEAR: assert property (rise.alarm_reset_input && alarm_present && !alarm_locked // [RQ8]
        && !alarm_event |=> !alarm_present) else $error("alarm not cleared");
    AST_ALM_LOCKED: assert property (alarm_present && alarm_locked && !alarm_event // [RQ8]
        |=> alarm_present && alarm_code == $past(alarm_code)) else $error("locked alarm lost");
    AST_ETO_CAUSE: assert property (external_torque_off_mode && eto_cause // [RQ9]
        |=> external_torque_off_mode) else $error("estop released with cause present");
    AST_ETO_LEVEL: assert property (eto_clear_mode == `MDIC_ETO_LEVEL && !eto_cause // [RQ10]
        && !eto_event && lvl.estop_clear_input |=> !external_torque_off_mode)
        else $error("level estop clear ignored");
    AST_INFO_AUTO: assert property (info_auto_clear && !info_cause // [RQ21]
        |=> !info_status) else $error("info not auto cleared");
    AST_INFO_HOLD: assert property (!info_auto_clear && info_status // [RQ12]
        && !lvl.info_clear_input |=> info_status) else $error("info released without clear");
    AST_TOOL_DEFAULT: assert property (tool_perm_assign == 2'h0 // [RQ14]
        |=> tool_access_allowed) else $error("unassigned permission not on");
    AST_LATCH_CLR: assert property (rise.latch_clear_input && latch_event == 4'h0 // [RQ11]
        && !pulse_lost_event && !load_strobe
        |=> latch_hold == 4'h0 && !pulse_lost_output && cumulative_load == 32'h0000_0000)
        else $error("latch clear incomplete");
    AST_PULSE_DISABLE_INPUT: assert property (lvl.pulse_disable_input // [RQ20]
        |=> $stable(command_pulse_count)) else $error("pulse counted while disabled");
    AST_POSITION_INPUT_A: assert property (rise.position_input_a // [RQ16]
        |=> position_input_a_write.valid && position_input_a_write.index == $past(lvl.data_select)
            && position_input_a_write.position == $past(positions.fb)) else $error("position_input_a write wrong");
    AST_PLS_START: assert property (pls_state == PLS_IDLE && mclk_rise && pulse_mode // [RQ4]
        && pls_count != 32'h0000_0000 |=> pulse_report_output ##1 pls_state != PLS_IDLE)
        else $error("pulse train did not start");

    COV_PLS_TRAIN: cover property (pls_state == PLS_LOW ##1 pls_state == PLS_IDLE);
    COV_ALM_RESET: cover property (alarm_present ##1 !alarm_present);
    COV_POSITION_INPUT_A: cover property (position_input_a_write.valid && position_input_a_write.type_valid);
    COV_MULT: cover property (rise.command_pulse && lvl.pulse_multiply_input);

endmodule : mdic_top

// ---- dv/mdic_host.sv ----
/*
 * Host controller model: makes the monitor shift clock only while go is
 * high and shifts in the monitor data. Assumes MSB-first serial output.
 */
`timescale 1ns/100ps
module mdic_host (
    input  wire logic        go,
    input  wire logic        ser,
    output logic             sclk,
    output logic [39:0]      word
);
    initial begin
        sclk = 1'b0;
        word = '0;
        forever begin
            wait (go);
            #32 sclk = 1'b1;
            // bit is settled half a period after the rising edge
            #32 sclk = 1'b0;
            word = {word[38:0], ser};
        end
    end
endmodule : mdic_host

// ---- dv/tb_mdic_top.sv ----
/*
 * Self-checking bench of mdic_top with the host controller model.
 * Assumes the design's registered outputs and pin synchronisers.
 */
`timescale 1ns/100ps
`include "mdic_defs.svh"
module tb_mdic_top
    import mdic_pkg::*;
;
    logic clk, rst, go, monitor_serial_output, alarm_event, alarm_event_locked, eto_event;
    logic eto_cause, info_cause, info_auto_clear, pulse_lost_event, load_strobe;
    logic alarm_present, external_torque_off_mode, info_status, tool_access_allowed;
    logic next_latch_output, shift_clk;
    logic [3:0] mon_sel0, mon_sel1, latch_event;
    logic [1:0] eto_clear_mode, tool_perm_assign;
    logic [7:0] alarm_event_code, position_input_a_type_setting;
    logic [4:0] pulse_multiply_factor;
    logic [31:0] command_pulse_count;
    logic [39:0] word;
    mdic_pins_t pins;
    mdic_pos_t positions;
    mdic_position_input_a_t position_input_a_write;
    int bad_count, samples_checked, cyc, i;
    mdic_host i_host (.go, .ser(monitor_serial_output), .sclk(shift_clk), .word);
    mdic_top i_dut (.clk, .rst, .monitor_shift_clock(shift_clk), .pins, .pulse_mode(1'b0),
        .mon_sel0, .mon_sel1, .pls_sel(2'h0), .pls_freq(14'h0064), .positions, .alarm_event,
        .alarm_event_code, .alarm_event_locked, .eto_event, .eto_cause, .eto_clear_mode,
        .info_cause, .info_auto_clear, .tool_perm_assign, .latch_event, .latch_now('0),
        .pulse_lost_event, .load_strobe, .load_sample(16'h0), .position_input_a_type_setting,
        .pulse_multiply_factor, .monitor_serial_output, .pulse_report_output(),
        .pulse_report_dir(), .alarm_present, .alarm_code(), .external_torque_off_mode,
        .info_status, .tool_access_allowed, .next_latch_output, .jump_zero_latch_output(),
        .jump_one_latch_output(), .latch_records(), .pulse_lost_output(),
        .cumulative_load(), .position_input_a_write, .command_pulse_count);
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask : w
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic frame(input int n);
        go = 1'b1;
        #(64 * n - 10) go = 1'b0;
        w(4);
    endtask : frame
    task automatic end_sim;
        if (bad_count == 0 && samples_checked > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) if (++cyc == 20000) begin
        bad_count++;
        end_sim();
    end
    initial begin
        // shift clock runs during reset so the link side is reset too
        {rst, go, alarm_event, alarm_event_locked, eto_event, eto_cause, info_cause} = 7'h61;
        {pulse_lost_event, load_strobe, info_auto_clear, latch_event} = 7'h10;
        {mon_sel0, mon_sel1, eto_clear_mode, tool_perm_assign} = 12'h380;
        {alarm_event_code, position_input_a_type_setting, pulse_multiply_factor} = {8'h5a, 8'h08, 5'h05};
        pins = '0;
        positions = {32'h8123_4567, 32'h0000_1f2e, 64'h0};
        w(5);
        {rst, go} = 2'h0;
        w(4);
        pins.monitor_request_0 = 1'b1;
        w(10);
        frame(34);
        chk(word[31:0], 32'h8123_4567);
        pins.monitor_request_0 = 1'b0;
        {alarm_event, alarm_event_locked} = 2'h3;
        w(1);
        alarm_event = 1'b0;
        pins.monitor_request_1 = 1'b1;
        w(10);
        frame(10);
        chk(word[7:0], 8'h5a);
        pins.monitor_request_1 = 1'b0;
        for (i = 0; i < 2; i++) begin
            pins.alarm_reset_input = 1'b1;
            w(8);
            chk(alarm_present, i == 0);
            pins.alarm_reset_input = 1'b0;
            {alarm_event, alarm_event_locked} = 2'h2;
            w(1);
            alarm_event = 1'b0;
            w(8);
        end
        {eto_event, eto_cause} = 2'h3;
        w(1);
        eto_event = 1'b0;
        pins.estop_clear_input = 1'b1;
        w(8);
        chk(external_torque_off_mode, 1'b1);
        {eto_cause, eto_clear_mode} = 3'h2;
        w(3);
        chk(external_torque_off_mode, 1'b0);
        pins.estop_clear_input = 1'b0;
        {info_auto_clear, info_cause} = 2'h1;
        w(1);
        info_cause = 1'b0;
        w(8);
        chk(info_status, 1'b1);
        pins.info_clear_input = 1'b1;
        w(8);
        chk(info_status, 1'b0);
        chk(tool_access_allowed, 1'b1);
        {tool_perm_assign, pins.tool_permission_direct} = 3'h7;
        w(8);
        chk(tool_access_allowed, 1'b0);
        latch_event = 4'h1;
        w(1);
        latch_event = 4'h0;
        pins.latch_clear_input = 1'b1;
        w(8);
        chk(next_latch_output, 1'b0);
        pins.data_select = 8'h2c;
        pins.position_input_a = 1'b1;
        for (i = 0; i < 12 && position_input_a_write.valid !== 1'b1; i++) w(1);
        chk({position_input_a_write.index, position_input_a_write.position}, 40'h2c_0000_1f2e);
        chk(position_input_a_write.op_type, `MDIC_POSITION_INPUT_A_WRAP);
        for (i = 0; i < 4; i++) begin
            {pins.pulse_multiply_input, pins.pulse_disable_input} = {i < 2, i == 2};
            w(18);
            pins.command_pulse = 1'b1;
            w(8);
            pins.command_pulse = 1'b0;
        end
        w(8);
        chk(command_pulse_count, 32'h0000_000b);
        end_sim();
    end
endmodule : tb_mdic_top
